// >>> core/hex_driver_regs.vh
// Constants for the serial/parallel hex driver.
// Notes on behaviour
// [RULE_01] Mode input high selects serial, low parallel.
// [RULE_02] Parallel mode: outputs follow control inputs directly.
// [RULE_03] Inputs one to three double as serial pins.
// [RULE_04] Host shifts six-bit word, most significant first.
// [RULE_05] Latch enable high copies shift register to outputs.
// [RULE_06] Serial clock ignored while latch enable high.
// [RULE_07] Serial out is input delayed six clocks.
// [RULE_08] Devices cascade through serial out to serial in.
// [RULE_09] Bit 0: true low, complement high; 1 reversed.
// [RULE_10] Shift on rising edge; outputs hold while latch low.
`ifndef HEX_DRIVER_REGS_VH
`define HEX_DRIVER_REGS_VH
`define HEX_WIDTH        6
`define HEX_SDI_BIT      0
`define HEX_SCK_BIT      1
`define HEX_LATCH_BIT    2
`define HEX_MODE_SERIAL  1'b1
`define HEX_LATCH_RESET  6'h00
`endif

// >>> core/hex_shift_reg.v
// Six-stage shift register with serial tail for cascading.
`timescale 1ns/1ps
`include "hex_driver_regs.vh"
module hex_shift_reg (
    // Clock and reset
    input  wire       i_core_clk,
    input  wire       i_rst_b,
    // Shift control
    input  wire       i_shift_en,
    input  wire       i_serial_data_in,
    // Contents and tail
    output reg  [5:0] o_word,
    output wire       o_serial_data_out
);
    // Each shift moves toward the top, so the first bit sent ends in bit 5.
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_word <= `HEX_LATCH_RESET;
        end else if (i_shift_en) begin
            o_word <= {o_word[4:0], i_serial_data_in}; // see [RULE_04]
        end
    end

    // The top stage is the tail, six shifts behind the input.
    assign o_serial_data_out = o_word[5]; // see [RULE_07]
endmodule

// >>> core/serial_parallel_hex_driver.v
// Top of the six-channel serial/parallel complementary driver.
`timescale 1ns/1ps
`include "hex_driver_regs.vh"
module serial_parallel_hex_driver (
    // Clock and reset
    input  wire       i_core_clk,
    input  wire       i_rst_b,
    // Device pins
    input  wire       i_mode_serial,
    input  wire [5:0] i_control_inputs,
    // Outputs
    output reg  [5:0] o_true_outputs,
    output reg  [5:0] o_complement_outputs,
    output reg        o_serial_data_out
);
    reg  [5:0] ctl_meta_r;
    reg  [5:0] ctl_sync_r;
    reg        mode_meta_r;
    reg        mode_sync_r;
    reg        sck_prev_r;
    reg  [5:0] latch_r;
    reg  [5:0] word_nxt;
    wire       sck;
    wire       latch_en;
    wire       sdi;
    wire       shift_en;
    wire [5:0] shift_word;
    wire       tail;

    // Two-stage synchronisers for every pin.
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            ctl_meta_r  <= 6'h00;
            ctl_sync_r  <= 6'h00;
            mode_meta_r <= 1'b0;
            mode_sync_r <= 1'b0;
        end else begin
            ctl_meta_r  <= i_control_inputs;
            ctl_sync_r  <= ctl_meta_r;
            mode_meta_r <= i_mode_serial;
            mode_sync_r <= mode_meta_r;
        end
    end

    // Shared pins take their serial meaning.
    assign sdi = ctl_sync_r[`HEX_SDI_BIT]; // see [RULE_03]
    assign sck = ctl_sync_r[`HEX_SCK_BIT]; // see [RULE_03]
    assign latch_en = ctl_sync_r[`HEX_LATCH_BIT]; // see [RULE_03]

    // Rising serial clock edge, masked while latching or in parallel mode.
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck;
        end
    end
    assign shift_en = (mode_sync_r == `HEX_MODE_SERIAL) && sck && !sck_prev_r
                      && !latch_en; // see [RULE_10] see [RULE_06]

    hex_shift_reg u_shift (
        .i_core_clk        (i_core_clk),
        .i_rst_b           (i_rst_b),
        .i_shift_en        (shift_en),
        .i_serial_data_in  (sdi),
        .o_word            (shift_word),
        .o_serial_data_out (tail)
    );

    // Output latch loads in serial mode while latch enable is high, otherwise holds.
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            latch_r <= `HEX_LATCH_RESET;
        end else if (mode_sync_r == `HEX_MODE_SERIAL && latch_en) begin
            latch_r <= shift_word; // see [RULE_05] see [RULE_10]
        end
    end

    // Mode select chooses the word that reaches the pins.
    always @* begin
        if (mode_sync_r == `HEX_MODE_SERIAL) begin
            word_nxt = latch_r; // see [RULE_01]
        end else begin
            // Bit n of the word is channel n+1, no latching.
            word_nxt = ctl_sync_r; // see [RULE_02]
        end
    end

    // Registered complementary drive and serial tail.
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_true_outputs       <= 6'h00;
            o_complement_outputs <= 6'h3F;
            o_serial_data_out    <= 1'b0;
        end else begin
            o_true_outputs       <= word_nxt;  // see [RULE_09]
            o_complement_outputs <= ~word_nxt; // see [RULE_09]
            o_serial_data_out    <= tail;      // see [RULE_08]
        end
    end
endmodule

// >>> tb/hex_assertions.sv
// Checker watching the hex driver pins.
`timescale 1ns/1ps
module hex_assertions (
    input wire       i_core_clk,
    input wire       i_rst_b,
    input wire       i_mode_serial,
    input wire [5:0] i_control_inputs,
    input wire [5:0] o_true_outputs,
    input wire [5:0] o_complement_outputs,
    input wire       o_serial_data_out
);
    // Short aliases keep the properties readable.
    wire       m = i_mode_serial;
    wire [5:0] c = i_control_inputs;
    wire       q = o_serial_data_out;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    a_comp_pair: assert property (o_complement_outputs == ~o_true_outputs)
        else $error("rails not complementary");
    a_reset_word: assert property (disable iff (1'b0) !i_rst_b |=> o_true_outputs == 6'h00)
        else $error("reset word wrong");
    a_reset_tail: assert property (disable iff (1'b0) !i_rst_b |=> !q)
        else $error("reset tail wrong");
    a_par_follow: assert property (!m [*6] |-> o_true_outputs == $past(c, 3))
        else $error("parallel outputs lag wrong");
    a_par_noshift: assert property (!m [*6] |-> $stable(q))
        else $error("shift in parallel mode");
    a_ser_hold: assert property ((m && !c[2]) [*6] |-> $stable(o_true_outputs))
        else $error("outputs moved without latch");
    a_tail_quiet: assert property ((!$rose(c[1])) [*6] |-> $stable(q))
        else $error("tail moved without clock");
    a_latch_load: assert property ((m && c[2] && !$rose(c[1])) [*7] |-> q == o_true_outputs[5])
        else $error("latched word differs");
    cover property (!m && $changed(o_true_outputs));
    cover property (m && $rose(c[2]));
    cover property ($rose(q));
endmodule
bind serial_parallel_hex_driver hex_assertions u_hex_assertions (.i_core_clk, .i_rst_b,
    .i_mode_serial, .i_control_inputs, .o_true_outputs, .o_complement_outputs, .o_serial_data_out);

// >>> tb/hex_host.sv
// Host model shifting words into the driver.
`timescale 1ns/1ps
module hex_host (
    output reg o_sdi,
    output reg o_sck,
    output reg o_latch_en
);
    initial {o_sdi, o_sck, o_latch_en} = 3'h0;
    // Sends a word most significant bit first; data is inverted once the frame ends.
    task send(input [5:0] w, input do_latch);
        integer k;
        for (k = 5; k >= 0; k--) begin
            o_sdi = w[k];
            #62.5 o_sck = 1'b1;
            #62.5 o_sck = 1'b0;
        end
        o_sdi = ~o_sdi;
        if (do_latch) begin
            #62.5 o_latch_en = 1'b1;
            #62.5 o_latch_en = 1'b0;
        end
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the serial/parallel hex driver.
`timescale 1ns/1ps
module testbench;
    reg        i_core_clk    = 1'b0;
    reg        i_rst_b       = 1'b0;
    reg        i_mode_serial = 1'b0;
    reg  [5:0] par           = 6'h00;
    wire       sdi, sck, latch_en, sdo;
    wire [5:0] tru, cmp;
    integer    errors = 0, check_count = 0, cyc = 0, k;
    // Serial mode routes the host pins onto the first three inputs.
    wire [5:0] ctl = i_mode_serial ? {par[5:3], latch_en, sck, sdi} : par;
    serial_parallel_hex_driver u_serial_parallel_hex_driver (.i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b), .i_mode_serial(i_mode_serial), .i_control_inputs(ctl),
        .o_true_outputs(tru), .o_complement_outputs(cmp), .o_serial_data_out(sdo));
    hex_host u_hex_host (.o_sdi(sdi), .o_sck(sck), .o_latch_en(latch_en));
    initial forever #4 i_core_clk = ~i_core_clk;
    // Cuts a hang short.
    always @(posedge i_core_clk) if (++cyc == 20000) begin errors++; end_of_test; end
    task chk(input string nm, input [5:0] seen, input [5:0] exp);
        check_count++;
        if (seen !== exp) begin errors++; $display("BAD %s exp %h seen %h", nm, exp, seen); end
    endtask
    task wait5;
        repeat (5) @(negedge i_core_clk);
    endtask
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        // Parallel words must show on both rails.
        for (k = 0; k < 4; k++) begin
            par = 6'h2A >> k;
            wait5;
            chk("true", tru, par);
            chk("comp", cmp, ~par);
        end
        // Serial mode keeps the last latched word until a load.
        i_mode_serial = 1'b1;
        wait5;
        chk("switch", tru, 6'h00);
        u_hex_host.send(6'h2D, 1'b1);
        wait5;
        chk("load", tru, 6'h2D);
        // Two words back to back, as for a chain of two.
        u_hex_host.send(6'h12, 1'b0);
        u_hex_host.send(6'h33, 1'b0);
        wait5;
        chk("hold", tru, 6'h2D);
        chk("tail", {5'h00, sdo}, 6'h01);
        end_of_test;
    end
    task end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
endmodule
